// [hdl/byte_port_defs.svh]
// Purpose: Register offsets, field positions and reset values of the
//          byte port with slave mode control.
// Assumes: Included by bare name from every file that needs it.
// Notes:   Definitions only.
`ifndef BYTE_PORT_DEFS_SVH
`define BYTE_PORT_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_BYTE_PORT_DATA      8'h08
`define OFF_CONTROL_PORT_DATA   8'h09
`define OFF_BYTE_PORT_DIR       8'h88
`define OFF_CTRL_DIR_STATUS     8'h89
`define OFF_ANALOG_PIN_CONFIG   8'h9f

// ----------------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------------
`define BIT_INPUT_FULL          7
`define BIT_OUTPUT_FULL         6
`define BIT_INPUT_OVERFLOW      5
`define BIT_SLAVE_SELECT        4
`define BIT_FETCH_STROBE        0
`define BIT_STORE_STROBE        1
`define BIT_CHIP_SELECT         2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE_PORT_DIR       8'hff
`define RST_CTRL_DIR            3'h7
`define RST_ANALOG_PIN_CONFIG   3'h0
// Map codes at or above this value leave all three control pins digital
`define ANALOG_MAP_ALL_DIGITAL  3'h7

`endif

// [hdl/byte_port_device.sv]
// Purpose: 8-bit port plus 3-pin control port with a byte-wide slave
//          mode for an external processor; CPU register port.
// Assumes: Pins synchronous to clk; one CPU access per cycle.
// Notes:   Rules carried by this block are listed below.
// Notes on behaviour
// - Eight data pins, each with direction bit
// - Control bit 4 selects slave mode
// - Three control pins, each separately directed
// - Control direction bits 2:0, 1 input
// - Slave mode: control pins are read/write/select
// - Software sets pins input and digital first
// - Analog-selected control pin reads zero
// - Direction bits apply even when analog
// - Software keeps analog pins as inputs
// - Power-on reset makes control pins analog
// - Read low with select drives latch out
// - Chip select is active low
// - Bit 7 input full, read only
// - Bit 6 output full, read only
// - Bit 5 overflow, sticky until cleared
// - Bit 3 reads zero
// - Reset loads control/status to 0000_0111
// - Select and store low write; release sets flag
// - Output full clears as external read begins
// - Full flags held clear outside slave mode
// - Slave mode ignores data direction register
`timescale 1ns/1ps
`include "byte_port_defs.svh"
module byte_port_device #(
    parameter int DATA_W = 8    // Data port width
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         por_n,          // Power-on reset, low
    input  wire logic         reg_wr,         // CPU register write
    input  wire logic         reg_rd,         // CPU register read
    input  wire logic [7:0]   reg_addr,       // CPU register offset
    input  wire logic [7:0]   reg_wdata,      // CPU write data
    output logic      [7:0]   reg_rdata,      // CPU read data, registered
    output logic              reg_rvalid,     // Read data valid pulse
    output logic              rx_valid,       // Buffered received byte
    output logic [DATA_W-1:0] rx_data,        // Buffered byte value
    input  wire logic         rx_ready,       // User takes buffered byte
    byte_slave_if.device      pins
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] out_latch_q;     // CPU-written data latch
    logic [DATA_W-1:0] in_latch_q;      // Externally written latch
    logic [DATA_W-1:0] dir_q;           // Data direction, 1 input
    logic [2:0]        ctrl_latch_q;    // Control port output latch
    logic [2:0]        ctrl_dir_q;      // Control direction, 1 input
    logic              slave_q;         // Slave mode select
    logic              ibf_q;           // Input full
    logic              obf_q;           // Output full
    logic              input_overflow_flag_q;          // Overflow, sticky
    logic [2:0]        analog_map_q;    // Analog pin map
    byte_port_pkg::xfer_state_t st_q;   // External access phase
    byte_port_pkg::xfer_state_t st_d;
    logic [DATA_W-1:0] dev_data_q;      // Registered data pin drive
    logic [DATA_W-1:0] dev_oe_q;        // Registered data pin enable
    // Two-entry buffer between the input latch and the user port
    logic [DATA_W-1:0] buf_q [2];
    logic              wp_q;            // Buffer write pointer
    logic              rp_q;            // Buffer read pointer
    logic [1:0]        cnt_q;           // Buffer occupancy

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire sel_n    = pins.ctrl_pins[`BIT_CHIP_SELECT];
    wire fetch_n  = pins.ctrl_pins[`BIT_FETCH_STROBE];
    wire store_n  = pins.ctrl_pins[`BIT_STORE_STROBE];
    wire ext_rd   = slave_q & ~sel_n & ~fetch_n;
    wire ext_wr   = slave_q & ~sel_n & ~store_n;
    wire wr_data  = reg_wr && reg_addr == `OFF_BYTE_PORT_DATA;
    wire wr_ctrl  = reg_wr && reg_addr == `OFF_CONTROL_PORT_DATA;
    wire wr_dir   = reg_wr && reg_addr == `OFF_BYTE_PORT_DIR;
    wire wr_stat  = reg_wr && reg_addr == `OFF_CTRL_DIR_STATUS;
    wire wr_an    = reg_wr && reg_addr == `OFF_ANALOG_PIN_CONFIG;
    wire rd_data  = reg_rd && reg_addr == `OFF_BYTE_PORT_DATA;
    // Write completes when select or strobe goes high again
    wire wr_done  = st_q == byte_port_pkg::XFER_WRITE && !ext_wr;
    wire rd_begin = st_q == byte_port_pkg::XFER_IDLE && ext_rd;
    wire buf_full = cnt_q == 2'd2;
    wire buf_push = wr_done && !buf_full;
    wire buf_pop  = rx_valid && rx_ready;
    // Head entry after this edge; a push into an empty buffer bypasses
    // the array so that the byte never lags its valid flag
    wire rp_next  = buf_pop ? ~rp_q : rp_q;
    wire [DATA_W-1:0] head_d = (buf_push && wp_q == rp_next)
                               ? in_latch_q : buf_q[rp_next];
    // Any map code short of all-digital masks the control pins
    wire analog_on = analog_map_q < `ANALOG_MAP_ALL_DIGITAL;
    wire [2:0] ctrl_read = analog_on ? 3'h0 : pins.ctrl_pins;
    wire [7:0] status = {ibf_q, obf_q, input_overflow_flag_q, slave_q,
                         1'b0, ctrl_dir_q};
    // Slave mode: drive the latch while select and read are low
    wire [DATA_W-1:0] oe_d = slave_q ? {DATA_W{ext_rd}}
                                     : ~dir_q;

    // ------------------------------------------------------------------
    // Access phase machine
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            byte_port_pkg::XFER_IDLE: begin
                if (ext_wr) st_d = byte_port_pkg::XFER_WRITE;
                else if (ext_rd) st_d = byte_port_pkg::XFER_READ;
            end
            byte_port_pkg::XFER_READ: begin
                if (!ext_rd) st_d = byte_port_pkg::XFER_IDLE;
            end
            byte_port_pkg::XFER_WRITE: begin
                if (!ext_wr) st_d = byte_port_pkg::XFER_IDLE;
            end
            default: st_d = byte_port_pkg::XFER_IDLE;
        endcase
    end

    // Phase register and latched write data
    always_ff @(posedge clk) begin
        if (!rst_n || !slave_q) begin
            st_q <= byte_port_pkg::XFER_IDLE;
        end else begin
            st_q <= st_d;
        end
        if (ext_wr) begin
            in_latch_q <= pins.data_pins;
        end
    end

    // ------------------------------------------------------------------
    // Control/status and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slave_q    <= 1'b0;
            ctrl_dir_q <= `RST_CTRL_DIR;
            ibf_q      <= 1'b0;
            obf_q      <= 1'b0;
            input_overflow_flag_q     <= 1'b0;
        end else begin
            if (wr_stat) begin
                slave_q    <= reg_wdata[`BIT_SLAVE_SELECT];
                ctrl_dir_q <= reg_wdata[2:0];
            end
            // Set beats a same-cycle software clear
            if (wr_done && ibf_q) begin
                input_overflow_flag_q <= 1'b1;
            end else if (wr_stat && !reg_wdata[`BIT_INPUT_OVERFLOW]) begin
                input_overflow_flag_q <= 1'b0;
            end
            if (!slave_q) begin
                ibf_q <= 1'b0;
                obf_q <= 1'b0;
            end else begin
                if (wr_done) ibf_q <= 1'b1;
                else if (rd_data) ibf_q <= 1'b0;
                if (rd_begin) obf_q <= 1'b0;
                else if (wr_data) obf_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Port latches and analog map
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!por_n) begin
            analog_map_q <= `RST_ANALOG_PIN_CONFIG;
        end else if (wr_an) begin
            analog_map_q <= reg_wdata[2:0];
        end
        if (!rst_n) begin
            dir_q <= `RST_BYTE_PORT_DIR;
        end else if (wr_dir) begin
            dir_q <= reg_wdata;
        end
        if (wr_data) out_latch_q <= reg_wdata;
        if (wr_ctrl) ctrl_latch_q <= reg_wdata[2:0];
    end

    // ------------------------------------------------------------------
    // Pin drive, registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dev_oe_q   <= '0;
            dev_data_q <= '0;
        end else begin
            dev_oe_q   <= oe_d;
            dev_data_q <= out_latch_q;
        end
    end
    assign pins.dev_data_o  = dev_data_q;
    assign pins.dev_data_oe = dev_oe_q;
    assign pins.dev_ctrl_o  = ctrl_latch_q;
    assign pins.dev_ctrl_oe = ~ctrl_dir_q;

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            unique case (reg_addr)
                `OFF_BYTE_PORT_DATA:
                    reg_rdata <= slave_q ? in_latch_q : pins.data_pins;
                `OFF_CONTROL_PORT_DATA: reg_rdata <= {5'h00, ctrl_read};
                `OFF_BYTE_PORT_DIR:     reg_rdata <= dir_q;
                `OFF_CTRL_DIR_STATUS:   reg_rdata <= status;
                `OFF_ANALOG_PIN_CONFIG: reg_rdata <= {5'h00, analog_map_q};
                default:                reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Two-entry receive buffer; a full buffer drops nothing the CPU
    // can still read from the latch, but the user copy is skipped
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'd0;
            rx_valid <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_q[wp_q] <= in_latch_q;
                wp_q        <= ~wp_q;
            end
            if (buf_pop) rp_q <= ~rp_q;
            cnt_q    <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
            rx_valid <= (cnt_q + {1'b0, buf_push}
                         - {1'b0, buf_pop}) != 2'd0;
        end
        rx_data <= head_d;
    end
endmodule : byte_port_device

// [hdl/byte_port_host.sv]
// Purpose: External processor end: runs single byte reads and writes
//          over the slave interface pins.
// Assumes: Device is in slave mode with control pins as inputs.
// Notes:   Strobe held low for HOLD_CYC cycles per access.
`timescale 1ns/1ps
`include "byte_port_defs.svh"
module byte_port_host #(
    parameter int HOLD_CYC = 4        // Strobe low time in cycles
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       req_valid,    // Access request
    input  wire logic       req_write,    // 1 write, 0 read
    input  wire logic [7:0] req_data,     // Write data
    output logic            req_ready,    // Request taken this cycle
    output logic            rsp_valid,    // Access finished pulse
    output logic [7:0]      rsp_data,     // Read data
    byte_slave_if.host      pins
);
    byte_port_pkg::xfer_state_t st_q;  // Current access
    logic [7:0] cnt_q;                 // Strobe time counter
    logic [7:0] wd_q;                  // Write data held
    logic       sel_n_q;               // Chip select, active low
    logic       fetch_n_q;             // Read strobe
    logic       store_n_q;             // Write strobe
    wire        idle = st_q == byte_port_pkg::XFER_IDLE;
    wire        last = cnt_q == 8'(HOLD_CYC - 1);

    // Access sequencer: select and strobe low together, then high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q      <= byte_port_pkg::XFER_IDLE;
            cnt_q     <= 8'h00;
            sel_n_q   <= 1'b1;
            fetch_n_q <= 1'b1;
            store_n_q <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            wd_q      <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            if (idle && req_valid) begin
                st_q      <= req_write ? byte_port_pkg::XFER_WRITE
                                       : byte_port_pkg::XFER_READ;
                wd_q      <= req_data;
                sel_n_q   <= 1'b0;
                fetch_n_q <= req_write;
                store_n_q <= ~req_write;
                cnt_q     <= 8'h00;
            end else if (!idle) begin
                cnt_q <= cnt_q + 8'h01;
                if (last) begin
                    if (st_q == byte_port_pkg::XFER_READ) begin
                        rsp_data <= pins.data_pins;
                    end
                    st_q      <= byte_port_pkg::XFER_IDLE;
                    sel_n_q   <= 1'b1;
                    fetch_n_q <= 1'b1;
                    store_n_q <= 1'b1;
                    rsp_valid <= 1'b1;
                end
            end
        end
    end

    assign req_ready         = idle;
    assign pins.select_n     = sel_n_q;
    assign pins.fetch_n      = fetch_n_q;
    assign pins.store_n      = store_n_q;
    assign pins.host_data_o  = wd_q;
    assign pins.host_data_oe = st_q == byte_port_pkg::XFER_WRITE;
endmodule : byte_port_host

// [hdl/byte_port_pkg.sv]
// Purpose: Types shared by both ends of the byte slave interface.
// Assumes: Nothing.
// Notes:   Constants live in byte_port_defs.svh.
package byte_port_pkg;
    // Phase of an external processor access; one bit flips per step
    typedef enum logic [1:0] {
        XFER_IDLE  = 2'b00,
        XFER_READ  = 2'b01,
        XFER_WRITE = 2'b10
    } xfer_state_t;
endpackage : byte_port_pkg

// [hdl/byte_slave_if.sv]
// Purpose: Pin-level carrier between the port device and the external
//          processor; resolves the two-way pins from the enables.
// Assumes: One driver per pin at a time.
// Notes:   Undriven pins float high (pull-up behaviour).
`timescale 1ns/1ps
interface byte_slave_if;
    // ------------------------------------------------------------------
    // Device side drive
    // ------------------------------------------------------------------
    logic [7:0] dev_data_o;     // Device data drive value
    logic [7:0] dev_data_oe;    // Device data enable, per bit
    logic [2:0] dev_ctrl_o;     // Device control pin drive value
    logic [2:0] dev_ctrl_oe;    // Device control pin enable
    // ------------------------------------------------------------------
    // Processor side drive
    // ------------------------------------------------------------------
    logic [7:0] host_data_o;    // Processor data drive value
    logic       host_data_oe;   // Processor data enable
    logic       fetch_n;        // Read strobe, active low
    logic       store_n;        // Write strobe, active low
    logic       select_n;       // Chip select, active low
    // ------------------------------------------------------------------
    // Resolved wire levels
    // ------------------------------------------------------------------
    logic [7:0] data_pins;      // Data wire level
    logic [2:0] ctrl_pins;      // Control wire level

    // Device enables win per bit; the processor otherwise
    assign data_pins = (dev_data_o & dev_data_oe)
                     | (~dev_data_oe & (host_data_oe ? host_data_o
                                                     : 8'hff));
    assign ctrl_pins = (dev_ctrl_o & dev_ctrl_oe)
                     | (~dev_ctrl_oe & {select_n, store_n, fetch_n});

    modport device (
        output dev_data_o, dev_data_oe, dev_ctrl_o, dev_ctrl_oe,
        input  data_pins, ctrl_pins
    );
    modport host (
        output host_data_o, host_data_oe, fetch_n, store_n, select_n,
        input  data_pins
    );
endinterface : byte_slave_if

// [testbench/byte_port_with_slave_mode_ctrl_bench.sv]
// Purpose: Self-checking bench for both ends of the byte slave link.
// Assumes: Host built with four hold cycles; seeded random data.
// Notes:   Expected values come from bench functions, literal constants and the random bytes.
`timescale 1ns/1ps
module byte_port_with_slave_mode_ctrl_bench;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic       clk = 1'b0;          // 100 MHz clock
    logic       rst_n = 1'b0;        // Sync reset
    logic       por_n = 1'b0;        // Power-on reset
    logic       reg_wr = 1'b0;       // CPU write strobe
    logic       reg_rd = 1'b0;       // CPU read strobe
    logic [7:0] reg_addr = 8'h00;    // CPU offset
    logic [7:0] reg_wdata = 8'h00;   // CPU write data
    logic [7:0] reg_rdata;           // CPU read data
    logic       reg_rvalid;          // Read data valid
    logic       rx_valid;            // Buffered byte present
    logic [7:0] rx_data;             // Buffered byte
    logic       rx_ready = 1'b0;     // Held low to stall the buffer
    logic       req_valid = 1'b0;    // Host request
    logic       req_write = 1'b0;    // Host direction
    logic [7:0] req_data = 8'h00;    // Host write data
    logic       req_ready;           // Host idle
    logic       rsp_valid;           // Host done
    logic [7:0] rsp_data;            // Host read data
    logic [7:0] a, b, c, d, v, dr, q; // Scratch bytes
    int         seed = 32'h46b7_d750; // Fixed seed, repeatable run
    int         n_mismatch = 0;      // Mismatch count
    int         tests_run = 0;       // Comparison count

    always #5 clk = ~clk;

    byte_slave_if bif ();
    byte_port_device byte_port_device_inst (.clk(clk), .rst_n(rst_n),
        .por_n(por_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .pins(bif));
    byte_port_host #(.HOLD_CYC(4)) byte_port_host_inst (.clk(clk),
        .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .pins(bif));
    byte_slave_checker byte_slave_checker_inst (.clk(clk), .rst_n(rst_n),
        .dev_data_oe(bif.dev_data_oe), .dev_ctrl_oe(bif.dev_ctrl_oe),
        .host_data_oe(bif.host_data_oe), .fetch_n(bif.fetch_n),
        .store_n(bif.store_n), .select_n(bif.select_n));

    // ------------------------------------------------------------
    // Expectations and bus tasks
    // ------------------------------------------------------------
    // Pin level: latch where output, float high where input
    function automatic logic [7:0] pin_read(logic [7:0] l, logic [7:0] m);
        return (l & ~m) | m;
    endfunction : pin_read
    // Status in slave mode with control pins as inputs
    function automatic logic [7:0] status(logic i, logic o, logic x);
        return {i, o, x, 5'h17};
    endfunction : status
    task automatic cmp8(input string what, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : cmp8
    // Bounded wait; a miss counts against the run
    task automatic await(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 40);
        if (s !== 1'b1) n_mismatch++;
    endtask : await
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ad;
        reg_wdata <= dt;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp8("read valid", 8'h01, {7'h00, reg_rvalid});
        cmp8($sformatf("reg %h", ad), e, reg_rdata);
    endtask : rd_chk
    task automatic xfer(input logic w, input logic [7:0] dt,
                        output logic [7:0] r);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_data  <= dt;
        await(req_ready);
        req_valid <= 1'b0;
        await(rsp_valid);
        r = rsp_data;
    endtask : xfer
    // One pop per call, so the buffer order shows
    task automatic pop_chk(input logic [7:0] e);
        await(rx_valid);
        cmp8("rx byte", e, rx_data);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask : pop_chk
    task automatic tally_and_finish;
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Watchdog well beyond the expected couple of hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rd_chk(8'h89, 8'h07);
        rd_chk(8'h88, 8'hff);
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h55, 8'h00);
        wr(8'h89, 8'hff);
        rd_chk(8'h89, 8'h17);
        wr(8'h9f, 8'h07);
        // Mixed directions, all-output first, in general mode
        for (int i = 0; i < 4; i++) begin
            v  = 8'($random(seed));
            dr = (i == 0) ? 8'h00 : 8'($random(seed));
            wr(8'h08, v);
            wr(8'h88, dr);
            wr(8'h09, v);
            wr(8'h89, {5'h00, dr[2:0]});
            rd_chk(8'h08, pin_read(v, dr));
            rd_chk(8'h09, pin_read(v, dr) & 8'h07);
        end
        wr(8'h89, 8'h07);
        wr(8'h9f, 8'h03);
        rd_chk(8'h09, 8'h00);
        // Outputs while analog on purpose: the wire must still follow
        wr(8'h89, 8'h00);
        rd_chk(8'h09, 8'h00);
        cmp8("ctrl wire", {5'h00, v[2:0]}, {5'h00, bif.ctrl_pins});
        wr(8'h88, 8'h00);
        wr(8'h9f, 8'h07);
        wr(8'h89, 8'h17);
        rd_chk(8'h09, 8'h07);
        a = 8'($random(seed));
        b = 8'($random(seed));
        c = 8'($random(seed));
        d = 8'($random(seed));
        wr(8'h08, a);
        rd_chk(8'h89, status(1'b0, 1'b1, 1'b0));
        xfer(1'b0, 8'h00, q);
        cmp8("host read", a, q);
        rd_chk(8'h89, status(1'b0, 1'b0, 1'b0));
        xfer(1'b1, b, q);
        repeat (2) @(posedge clk);
        rd_chk(8'h89, status(1'b1, 1'b0, 1'b0));
        xfer(1'b1, c, q);
        xfer(1'b1, d, q);
        rd_chk(8'h08, d);
        rd_chk(8'h89, status(1'b0, 1'b0, 1'b1));
        wr(8'h89, 8'h37);
        rd_chk(8'h89, status(1'b0, 1'b0, 1'b1));
        wr(8'h89, 8'h17);
        rd_chk(8'h89, status(1'b0, 1'b0, 1'b0));
        pop_chk(b);
        pop_chk(c);
        repeat (2) @(posedge clk);
        cmp8("rx empty", 8'h00, {7'h00, rx_valid});
        xfer(1'b1, a, q);
        xfer(1'b1, d, q);
        wr(8'h08, c);
        wr(8'h89, 8'h27);
        rd_chk(8'h89, 8'h27);
        tally_and_finish;
    end
endmodule : byte_port_with_slave_mode_ctrl_bench

// [testbench/byte_slave_checker.sv]
// Purpose: Wire checks between the port device and the host end.
// Assumes: Host runs only in slave mode with four hold cycles.
// Notes:   Takes the carrier signals as plain inputs.
`timescale 1ns/1ps
module byte_slave_checker (
    input wire logic       clk,          // System clock
    input wire logic       rst_n,        // Sync reset, low
    input wire logic [7:0] dev_data_oe,  // Device data enables
    input wire logic [2:0] dev_ctrl_oe,  // Device control enables
    input wire logic       host_data_oe, // Host data enable
    input wire logic       fetch_n,      // Read strobe, low
    input wire logic       store_n,      // Write strobe, low
    input wire logic       select_n      // Chip select, low
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_idle; // Host leaves reset with every strobe idle
        $rose(rst_n) |-> select_n && fetch_n && store_n; endproperty
    a_idle: assert property (p_idle)
        else $error("strobes not idle after reset");
    property p_read_drive; // Selected read turns the data pins around
        $fell(fetch_n) && !select_n |-> ##[1:3] dev_data_oe == 8'hff;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("device not driving during read");
    property p_release; // Deselect hands the pins back within bound
        $rose(select_n) |-> ##[1:3] dev_data_oe == 8'h00; endproperty
    a_release: assert property (p_release)
        else $error("device still driving after deselect");
    property p_no_fight; // Direction register ignored in slave mode
        host_data_oe |-> dev_data_oe == 8'h00; endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the data pins");
    property p_ctrl_in; // Control pins stay inputs while selected
        !select_n |-> dev_ctrl_oe == 3'b000; endproperty
    a_ctrl_in: assert property (p_ctrl_in)
        else $error("device drives a control pin");
    property p_store; // Write strobe only with data and select
        $fell(store_n) |-> host_data_oe && !select_n; endproperty
    a_store: assert property (p_store)
        else $error("write strobe without data or select");
    property p_len; // Select low for exactly four cycles
        $fell(select_n) |-> (!select_n) [*4] ##1 select_n; endproperty
    a_len: assert property (p_len)
        else $error("select low time wrong");
    property p_gap; // At least two idle cycles between accesses
        $rose(select_n) |=> select_n; endproperty
    a_gap: assert property (p_gap)
        else $error("no idle cycle between accesses");

    c_read: cover property (!select_n && !fetch_n ##1 !fetch_n);
    c_write: cover property (!select_n && !store_n ##1 !store_n);
    c_back: cover property ($rose(select_n) ##3 $fell(select_n));
endmodule : byte_slave_checker
